// ===== verilog/mmd_map.svh
// Address map constants for the memory map decoder
`ifndef MMD_MAP_SVH
`define MMD_MAP_SVH

// Code space
`define MMD_NOP_OPCODE 8'h00
`define MMD_CODE_TOP 16'hf7ff
`define MMD_NOP_BASE 16'hf800
`define MMD_REWRITE_LIMIT 16'he000

// General purpose RAM
`define MMD_IRAM_UPPER 8'h80
`define MMD_BIT_AREA_BASE 8'h20
`define MMD_BIT_SFR_BASE 8'h80

// Stack
`define MMD_SP_RESET 11'h007
`define MMD_SP_STEP 11'h001
`define MMD_STACK_IRAM_TOP 11'h0ff

// Extended data RAM window
`define MMD_EXTENDED_DATA_RAM_TOP 24'h0007ff

// Nonvolatile data memory access registers in SFR space
`define MMD_NV_CTRL 8'hb9
`define MMD_NV_DATA1 8'hbc
`define MMD_NV_DATA2 8'hbd
`define MMD_NV_DATA3 8'hbe
`define MMD_NV_DATA4 8'hbf
`define MMD_NV_ADDR 8'hc6

// Value returned from an unoccupied SFR location
`define MMD_UNOCC_RDATA 8'h00

`endif

// ===== verilog/mmd_pkg.sv
// Types shared by the memory map decoder modules
package mmd_pkg;
    // Strap capture sequence, one-hot
    typedef enum logic [2:0] {
        MMD_ST_SYNC1 = 3'b001,
        MMD_ST_SYNC2 = 3'b010,
        MMD_ST_RUN = 3'b100
    } mmd_strap_e;

    // Stack pointer and stack address width
    typedef logic [10:0] mmd_sp_t;
endpackage

// ===== verilog/mmd_stack_if.sv
// Interface between the decoder and its stack pointer unit
`timescale 1ns/100ps
interface mmd_stack_if;
    import mmd_pkg::*;
    logic push; // Pre-increment, then store
    logic pop; // Read, then decrement
    logic load; // Software load of the pointer
    mmd_sp_t load_val; // Value for a load
    mmd_sp_t sp; // Current stack pointer
    mmd_sp_t stack_addr; // Address of the current stack access

    modport core (output push, output pop, output load, output load_val, input sp, input stack_addr);
    modport unit (input push, input pop, input load, input load_val, output sp, output stack_addr);
endinterface

// ===== verilog/mmd_stack_unit.sv
// Stack pointer register with pre-increment push and post-decrement pop
`timescale 1ns/100ps
`include "mmd_map.svh"
module mmd_stack_unit (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Stack requests from the core side
    mmd_stack_if.unit stk
);
    import mmd_pkg::*;

    mmd_sp_t sp_reg; // Stack pointer
    mmd_sp_t sp_next; // Next stack pointer
    mmd_sp_t addr_calc; // Address for this cycle's access

    ////////////////////////////////////////////////////////////////////
    // Next pointer; load wins over push and pop
    always_comb begin
        sp_next = sp_reg;
        addr_calc = sp_reg;
        if (stk.load) begin
            sp_next = stk.load_val;
        end else if (stk.push) begin
            // Increment first so the first byte lands one above reset value
            addr_calc = 11'(sp_reg + `MMD_SP_STEP);
            sp_next = addr_calc;
        end else if (stk.pop) begin
            // Full 11-bit pointer lets the stack grow past the RAM top
            sp_next = 11'(sp_reg - `MMD_SP_STEP);
        end
    end

    // Pointer register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sp_reg <= `MMD_SP_RESET;
        end else begin
            sp_reg <= sp_next;
        end
    end

    assign stk.sp = sp_reg;
    assign stk.stack_addr = addr_calc;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_sp_reset_value: assert property ($rose(rst_n) |-> sp_reg == 11'h007)
        else $error("stack pointer not 07h after reset");
    a_push_preinc: assert property (stk.push && !stk.load |-> stk.stack_addr == 11'(sp_reg + 11'h001)
        ##1 sp_reg == $past(stk.stack_addr))
        else $error("push did not pre-increment");
    a_pop_wide: assert property (stk.pop && !stk.push && !stk.load |=> sp_reg == 11'($past(sp_reg) - 11'h001))
        else $error("pop did not decrement full pointer");
endmodule

// ===== verilog/mmd_decoder.sv
// Memory map decoder: code, internal RAM, stack, SFR and external data routing
`timescale 1ns/100ps
`include "mmd_map.svh"
module mmd_decoder (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Code select strap pin, asynchronous
    input wire logic external_code_select_pin,
    // Code fetch from the core
    input wire logic fetch_req,
    input wire logic [15:0] fetch_addr,
    input wire logic [7:0] flash_rdata,
    input wire logic [7:0] ext_code_rdata,
    output logic fetch_ext_sel,
    output logic [7:0] fetch_data,
    output logic fetch_valid,
    output logic code_internal,
    output logic map_ready,
    // Runtime program memory rewrite
    input wire logic prog_wr_req,
    input wire logic [15:0] prog_addr,
    output logic prog_wr_grant,
    // SFR space access
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_core_rdata,
    output logic sfr_occupied,
    output logic nvdata_sel,
    output logic [7:0] sfr_rdata,
    // Internal RAM access
    input wire logic [7:0] ram_addr,
    input wire logic ram_indirect,
    output logic iram_sel,
    output logic sfr_sel,
    // Register bank and bit addressing
    input wire logic [1:0] bank_sel,
    input wire logic [2:0] reg_idx,
    input wire logic [7:0] bit_addr,
    output logic [7:0] reg_ram_addr,
    output logic [7:0] bit_byte_addr,
    output logic [2:0] bit_pos,
    output logic bit_in_sfr,
    // Stack control
    input wire logic sp_push,
    input wire logic sp_pop,
    input wire logic sp_load,
    input wire logic [10:0] sp_load_val,
    output logic [10:0] stack_pointer,
    output logic [10:0] stack_addr,
    output logic stack_in_extended_data_ram,
    // External data moves
    input wire logic xdata_req,
    input wire logic [23:0] data_pointer,
    input wire logic internal_extended_data_ram_enable_bit,
    output logic xdata_internal,
    output logic xdata_external,
    output logic [10:0] extended_data_ram_addr
);
    import mmd_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Strap synchroniser and capture

    logic strap_s1_reg; // First stage, read only by the second
    logic strap_s2_reg; // Second stage, safe to use
    mmd_strap_e st_reg; // Capture sequence state
    mmd_strap_e st_next; // Next capture state
    logic code_int_reg; // Latched code memory selection
    logic code_int_next; // Next selection

    // Next capture state; the strap is looked at exactly once
    always_comb begin
        st_next = st_reg;
        code_int_next = code_int_reg;
        case (st_reg)
            MMD_ST_SYNC1: begin
                // Pin level still travelling through the synchroniser
                st_next = MMD_ST_SYNC2;
            end
            MMD_ST_SYNC2: begin
                st_next = MMD_ST_RUN;
                // High selects internal flash, low selects external code
                code_int_next = strap_s2_reg;
            end
            MMD_ST_RUN: begin
                // Later strap changes are ignored until the next reset
                st_next = MMD_ST_RUN;
            end
            default: begin
                st_next = MMD_ST_SYNC1;
            end
        endcase
    end

    // Synchroniser runs through reset, so the second stage holds the pin level at release
    always_ff @(posedge ref_clk) begin
        strap_s1_reg <= external_code_select_pin;
        strap_s2_reg <= strap_s1_reg;
    end

    // Capture registers; the reset value is a constant, the strap is taken later
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_reg <= MMD_ST_SYNC1;
            code_int_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            code_int_reg <= code_int_next;
        end
    end

    assign code_internal = code_int_reg;
    assign map_ready = (st_reg == MMD_ST_RUN);

    ////////////////////////////////////////////////////////////////////
    // Code fetch path

    logic fetch_nop; // Fetch falls in the unbacked top of code space
    logic [7:0] fetch_data_reg; // Returned opcode
    logic [7:0] fetch_data_next;
    logic fetch_valid_reg; // Opcode ready flag
    logic fetch_valid_next;

    // Fetches go external when the strap chose external code, and also from reset until the strap is captured
    assign fetch_ext_sel = !code_int_reg;
    // No rollover into external space from the internal top
    assign fetch_nop = code_int_reg && (fetch_addr >= `MMD_NOP_BASE);

    // Choose the opcode source
    always_comb begin
        fetch_valid_next = fetch_req && map_ready;
        if (fetch_nop) begin
            fetch_data_next = `MMD_NOP_OPCODE;
        end else if (code_int_reg) begin
            fetch_data_next = flash_rdata;
        end else begin
            fetch_data_next = ext_code_rdata;
        end
    end

    // Register the opcode so the core sees a clean value
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fetch_data_reg <= `MMD_NOP_OPCODE;
            fetch_valid_reg <= 1'b0;
        end else begin
            fetch_data_reg <= fetch_data_next;
            fetch_valid_reg <= fetch_valid_next;
        end
    end

    assign fetch_data = fetch_data_reg;
    assign fetch_valid = fetch_valid_reg;

    // Only the low region may be rewritten; the top holds the loader and is kept safe
    assign prog_wr_grant = prog_wr_req && (prog_addr < `MMD_REWRITE_LIMIT);

    ////////////////////////////////////////////////////////////////////
    // SFR decode

    logic sfr_occ_c; // Address has a register behind it
    logic [7:0] sfr_rdata_reg;
    logic [7:0] sfr_rdata_next;

    // Classic 8052 register set plus the nonvolatile access group
    function automatic logic sfr_is_occupied(input logic [7:0] a);
        logic occ;
        occ = 1'b0;
        if (a >= 8'h80 && a <= 8'h87) begin
            occ = 1'b1;
        end
        if (a >= 8'h88 && a <= 8'h8d) begin
            occ = 1'b1;
        end
        case (a)
            8'h90, 8'h98, 8'h99, 8'ha0, 8'ha8, 8'hb0, 8'hb8, 8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd,
            8'hd0, 8'he0, 8'hf0, `MMD_NV_CTRL, `MMD_NV_DATA1, `MMD_NV_DATA2, `MMD_NV_DATA3,
            `MMD_NV_DATA4, `MMD_NV_ADDR: begin
                occ = 1'b1;
            end
            default: begin
                occ = occ;
            end
        endcase
        return occ;
    endfunction

    assign sfr_occ_c = sfr_is_occupied(sfr_addr);
    assign sfr_occupied = sfr_occ_c;
    // Data memory has no direct window; only these registers reach it
    assign nvdata_sel = (sfr_addr == `MMD_NV_CTRL) || (sfr_addr == `MMD_NV_ADDR) ||
        (sfr_addr >= `MMD_NV_DATA1 && sfr_addr <= `MMD_NV_DATA4);

    // Read data; nothing answers for an empty location, so a fixed value returns
    always_comb begin
        sfr_rdata_next = sfr_rdata_reg;
        if (sfr_rd) begin
            sfr_rdata_next = sfr_occ_c ? sfr_core_rdata : `MMD_UNOCC_RDATA;
        end
    end

    // Read data register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sfr_rdata_reg <= `MMD_UNOCC_RDATA;
        end else begin
            sfr_rdata_reg <= sfr_rdata_next;
        end
    end

    assign sfr_rdata = sfr_rdata_reg;

    ////////////////////////////////////////////////////////////////////
    // Internal RAM, banks and bits

    // Upper half shares addresses with SFRs; mode decides which answers
    assign iram_sel = (ram_addr < `MMD_IRAM_UPPER) || ram_indirect;
    assign sfr_sel = (ram_addr >= `MMD_IRAM_UPPER) && !ram_indirect;
    assign reg_ram_addr = {3'b000, bank_sel, reg_idx};

    // Low bit addresses map into the bit area, high ones into SFR bytes
    always_comb begin
        bit_pos = bit_addr[2:0];
        bit_in_sfr = bit_addr[7];
        if (!bit_addr[7]) begin
            bit_byte_addr = 8'(`MMD_BIT_AREA_BASE + {4'h0, bit_addr[6:3]});
        end else begin
            bit_byte_addr = {bit_addr[7:3], 3'b000};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Stack

    mmd_stack_if stk ();

    assign stk.push = sp_push;
    assign stk.pop = sp_pop;
    assign stk.load = sp_load;
    assign stk.load_val = sp_load_val;

    mmd_stack_unit u_stack (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .stk(stk)
    );

    assign stack_pointer = stk.sp;
    assign stack_addr = stk.stack_addr;
    // Past the internal RAM top the stack continues in extended RAM
    assign stack_in_extended_data_ram = (stk.stack_addr > `MMD_STACK_IRAM_TOP);

    ////////////////////////////////////////////////////////////////////
    // External data moves

    logic extended_data_ram_hit; // Pointer inside the on-chip window

    assign extended_data_ram_hit = internal_extended_data_ram_enable_bit && (data_pointer <= `MMD_EXTENDED_DATA_RAM_TOP);
    assign xdata_internal = xdata_req && extended_data_ram_hit;
    assign xdata_external = xdata_req && !extended_data_ram_hit;
    assign extended_data_ram_addr = data_pointer[10:0];

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_strap_capture: assert property ($rose(rst_n) ##1 1'b1 |-> ##1 code_internal == $past(external_code_select_pin, 3))
        else $error("strap level not captured after release");
    a_strap_hold: assert property (map_ready && $past(map_ready) |-> $stable(code_internal))
        else $error("code selection changed without reset");
    a_ready_timing: assert property ($rose(rst_n) |-> !map_ready ##1 !map_ready ##1 map_ready)
        else $error("map ready at wrong edge");
    a_nop_top: assert property (fetch_req && map_ready && code_internal && fetch_addr > 16'hf7ff
        |=> fetch_valid && fetch_data == 8'h00)
        else $error("top code fetch did not return NOP");
    a_ext_fetch: assert property (fetch_req && map_ready && !code_internal
        |-> fetch_ext_sel ##1 fetch_valid && fetch_data == $past(ext_code_rdata))
        else $error("external fetch not routed");
    a_prog_limit: assert property (prog_wr_grant |-> prog_addr <= 16'hdfff)
        else $error("rewrite granted above limit");
    a_upper_direct: assert property (ram_addr[7] && !ram_indirect |-> sfr_sel && !iram_sel)
        else $error("direct upper address reached RAM");
    a_bit_area: assert property (!bit_addr[7] |-> bit_byte_addr >= 8'h20 && bit_byte_addr <= 8'h2f)
        else $error("bit address outside bit area");
    a_extended_data_ram_route: assert property (xdata_req && data_pointer > 24'h0007ff |-> xdata_external && !xdata_internal)
        else $error("high pointer routed on chip");
    a_extended_data_ram_enable: assert property (xdata_req && !internal_extended_data_ram_enable_bit |-> xdata_external)
        else $error("disabled window still on chip");
    a_unocc_read: assert property (sfr_rd && !sfr_occupied |=> sfr_rdata == 8'h00)
        else $error("unoccupied read returned register data");
endmodule

// ===== tb/mmd_mem_model.sv
// Code memory model standing for the internal flash and the external code bus
`timescale 1ns/100ps
module mmd_mem_model (
    // Fetch address from the core
    input wire logic [15:0] fetch_addr,
    // Data returned in the same cycle
    output logic [7:0] flash_rdata,
    output logic [7:0] ext_code_rdata
);
    ////////////////////////////////////////////////////////////////////////////
    // Distinct patterns so a wrong source is always visible, and a forced NOP is visible except at low byte 3Ch
    always_comb begin
        flash_rdata = fetch_addr[7:0] ^ 8'h3c;
        ext_code_rdata = fetch_addr[7:0] ^ 8'hc3;
    end
endmodule

// ===== tb/mmd_decoder_tb.sv
// Self-checking testbench for the memory map decoder
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module mmd_decoder_tb;
    // Clock, reset and all block inputs, driven at the falling edge
    logic ref_clk = 1'b0, rst_n = 1'b0, pin = 1'b1;
    logic fetch_req = 1'b0, prog_wr_req = 1'b0, sfr_rd = 1'b0, ram_indirect = 1'b0;
    logic sp_push = 1'b0, sp_pop = 1'b0, sp_load = 1'b0, xdata_req = 1'b0, xen = 1'b0;
    logic [15:0] fetch_addr = 16'h0000, prog_addr = 16'h0000;
    logic [7:0] sfr_addr = 8'h00, sfr_core_rdata = 8'h00, ram_addr = 8'h00, bit_addr = 8'h00;
    logic [1:0] bank_sel = 2'h0;
    logic [2:0] reg_idx = 3'h0;
    logic [10:0] sp_load_val = 11'h000;
    logic [23:0] data_pointer = 24'h000000;
    // Block outputs
    logic [7:0] flash_rdata, ext_code_rdata, fetch_data, sfr_rdata, reg_ram_addr, bit_byte_addr;
    logic fetch_ext_sel, fetch_valid, code_internal, map_ready, prog_wr_grant, sfr_occupied;
    logic nvdata_sel, iram_sel, sfr_sel, bit_in_sfr, stack_in_extended_data_ram, xdata_internal, xdata_external;
    logic [2:0] bit_pos;
    logic [10:0] stack_pointer, stack_addr, extended_data_ram_addr;
    int error_cnt = 0, num_checks = 0, cyc = 0;

    ////////////////////////////////////////////////////////////////////////////
    // 100 MHz clock and a cycle ceiling that cuts a hang short
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            stop_test();
        end
    end

    mmd_mem_model i_mmd_mem_model (.fetch_addr(fetch_addr), .flash_rdata(flash_rdata),
        .ext_code_rdata(ext_code_rdata));
    mmd_decoder i_mmd_decoder (.ref_clk(ref_clk), .rst_n(rst_n), .external_code_select_pin(pin),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr), .flash_rdata(flash_rdata),
        .ext_code_rdata(ext_code_rdata), .fetch_ext_sel(fetch_ext_sel), .fetch_data(fetch_data),
        .fetch_valid(fetch_valid), .code_internal(code_internal), .map_ready(map_ready),
        .prog_wr_req(prog_wr_req), .prog_addr(prog_addr), .prog_wr_grant(prog_wr_grant),
        .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_core_rdata(sfr_core_rdata),
        .sfr_occupied(sfr_occupied), .nvdata_sel(nvdata_sel), .sfr_rdata(sfr_rdata),
        .ram_addr(ram_addr), .ram_indirect(ram_indirect), .iram_sel(iram_sel), .sfr_sel(sfr_sel),
        .bank_sel(bank_sel), .reg_idx(reg_idx), .bit_addr(bit_addr), .reg_ram_addr(reg_ram_addr),
        .bit_byte_addr(bit_byte_addr), .bit_pos(bit_pos), .bit_in_sfr(bit_in_sfr),
        .sp_push(sp_push), .sp_pop(sp_pop), .sp_load(sp_load), .sp_load_val(sp_load_val),
        .stack_pointer(stack_pointer), .stack_addr(stack_addr), .stack_in_extended_data_ram(stack_in_extended_data_ram),
        .xdata_req(xdata_req), .data_pointer(data_pointer), .internal_extended_data_ram_enable_bit(xen),
        .xdata_internal(xdata_internal), .xdata_external(xdata_external), .extended_data_ram_addr(extended_data_ram_addr));

    ////////////////////////////////////////////////////////////////////////////
    // Reset for 8 cycles with a given strap level, then wait for the capture
    task automatic do_reset(input logic lvl);
        @(negedge ref_clk);
        rst_n = 1'b0;
        pin = lvl;
        repeat (8) @(negedge ref_clk);
        `CHK("sp_reset", 11'h007, stack_pointer)
        rst_n = 1'b1;
        // Fetches before the strap is captured are refused
        fetch_req = 1'b1;
        @(negedge ref_clk);
        `CHK("fetch_refused0", 1'b0, fetch_valid)
        @(negedge ref_clk);
        `CHK("fetch_refused1", 1'b0, fetch_valid)
        fetch_req = 1'b0;
        @(negedge ref_clk);
        `CHK("map_ready", 1'b1, map_ready)
    endtask

    // One fetch: request held for one edge, answer seen one cycle later
    task automatic fetch(input logic [15:0] a, input logic [7:0] e, input logic ext);
        @(negedge ref_clk);
        fetch_req = 1'b1;
        fetch_addr = a;
        #1 `CHK("fetch_ext_sel", ext, fetch_ext_sel)
        @(negedge ref_clk);
        fetch_req = 1'b0;
        `CHK("fetch_valid", 1'b1, fetch_valid)
        `CHK("fetch_data", e, fetch_data)
    endtask

    // One stack operation; pointer checked a cycle after its edge
    task automatic stk(input logic ps, input logic pp, input logic [10:0] ea, input logic [10:0] ep);
        @(negedge ref_clk);
        sp_push = ps;
        sp_pop = pp;
        #1 `CHK("stack_addr", ea, stack_addr)
        @(negedge ref_clk);
        sp_push = 1'b0;
        sp_pop = 1'b0;
        `CHK("stack_pointer", ep, stack_pointer)
    endtask

    // One SFR read with its occupancy and access group decode
    task automatic sfr(input logic [7:0] a, input logic occ, input logic nv, input logic [7:0] e);
        @(negedge ref_clk);
        // Read strobe only; the bench never writes an SFR or a reserved bit
        sfr_rd = 1'b1;
        sfr_addr = a;
        sfr_core_rdata = 8'h5a;
        #1 `CHK("sfr_occupied", occ, sfr_occupied)
        `CHK("nvdata_sel", nv, nvdata_sel)
        @(negedge ref_clk);
        sfr_rd = 1'b0;
        `CHK("sfr_rdata", e, sfr_rdata)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Strap high: internal code, top 2K reads NOP, selection survives pin change
    task automatic test_internal_code();
        do_reset(1'b1);
        `CHK("code_internal", 1'b1, code_internal)
        fetch(16'hf7ff, 8'hff ^ 8'h3c, 1'b0);
        fetch(16'hf800, 8'h00, 1'b0);
        pin = 1'b0;
        fetch(16'hffff, 8'h00, 1'b0);
        repeat (4) @(negedge ref_clk);
        `CHK("code_internal_kept", 1'b1, code_internal)
        $display("test internal_code done");
    endtask

    // Strap low: every fetch goes to the external bus, top space included
    task automatic test_external_code();
        do_reset(1'b0);
        `CHK("code_internal", 1'b0, code_internal)
        fetch(16'h0012, 8'h12 ^ 8'hc3, 1'b1);
        fetch(16'hf900, 8'h00 ^ 8'hc3, 1'b1);
        $display("test external_code done");
    endtask

    // Runtime rewrite window ends just below E000h
    task automatic test_rewrite();
        @(negedge ref_clk);
        prog_wr_req = 1'b1;
        prog_addr = 16'hdfff;
        #1 `CHK("grant_in", 1'b1, prog_wr_grant)
        @(negedge ref_clk);
        prog_addr = 16'he000;
        #1 `CHK("grant_out", 1'b0, prog_wr_grant)
        @(negedge ref_clk);
        prog_wr_req = 1'b0;
        $display("test rewrite done");
    endtask

    // Access group, occupied and unoccupied locations
    task automatic test_sfr();
        sfr(8'hb9, 1'b1, 1'b1, 8'h5a);
        sfr(8'hc6, 1'b1, 1'b1, 8'h5a);
        sfr(8'hc0, 1'b0, 1'b0, 8'h00);
        sfr(8'h81, 1'b1, 1'b0, 8'h5a);
        $display("test sfr done");
    endtask

    // Direct/indirect split, register banks and bit area at both ends
    task automatic test_ram();
        @(negedge ref_clk);
        ram_addr = 8'h80;
        bank_sel = 2'h3;
        reg_idx = 3'h7;
        bit_addr = 8'h7f;
        #1 `CHK("sfr_sel", 1'b1, sfr_sel)
        `CHK("iram_sel", 1'b0, iram_sel)
        `CHK("reg_ram_addr", 8'h1f, reg_ram_addr)
        `CHK("bit_byte", 8'h2f, bit_byte_addr)
        `CHK("bit_pos", 3'h7, bit_pos)
        `CHK("bit_in_sfr", 1'b0, bit_in_sfr)
        @(negedge ref_clk);
        ram_indirect = 1'b1;
        bank_sel = 2'h1;
        reg_idx = 3'h0;
        bit_addr = 8'h00;
        #1 `CHK("iram_sel_ind", 1'b1, iram_sel)
        `CHK("reg_ram_addr", 8'h08, reg_ram_addr)
        `CHK("bit_byte", 8'h20, bit_byte_addr)
        @(negedge ref_clk);
        ram_indirect = 1'b0;
        ram_addr = 8'h7f;
        bit_addr = 8'he5;
        #1 `CHK("iram_sel_low", 1'b1, iram_sel)
        `CHK("sfr_sel_low", 1'b0, sfr_sel)
        `CHK("bit_byte_sfr", 8'he0, bit_byte_addr)
        `CHK("bit_pos_sfr", 3'h5, bit_pos)
        `CHK("bit_in_sfr_hi", 1'b1, bit_in_sfr)
        $display("test ram done");
    endtask

    // First push lands at 08h; the stack grows past the internal RAM top
    task automatic test_stack();
        stk(1'b1, 1'b0, 11'h008, 11'h008);
        stk(1'b0, 1'b1, 11'h008, 11'h007);
        @(negedge ref_clk);
        sp_load = 1'b1;
        sp_load_val = 11'h0ff;
        @(negedge ref_clk);
        sp_load = 1'b0;
        stk(1'b1, 1'b0, 11'h100, 11'h100);
        `CHK("stack_in_extended_data_ram", 1'b1, stack_in_extended_data_ram)
        $display("test stack done");
    endtask

    // On-chip window only with the enable bit and a pointer up to 0007FFh
    task automatic test_xdata();
        @(negedge ref_clk);
        xdata_req = 1'b1;
        xen = 1'b1;
        data_pointer = 24'h0007ff;
        #1 `CHK("xd_int", 1'b1, xdata_internal)
        `CHK("extended_data_ram_addr", 11'h7ff, extended_data_ram_addr)
        `CHK("xd_ext_lo", 1'b0, xdata_external)
        @(negedge ref_clk);
        data_pointer = 24'h000800;
        #1 `CHK("xd_ext_hi", 1'b1, xdata_external)
        @(negedge ref_clk);
        data_pointer = 24'h010000;
        #1 `CHK("xd_int_hi", 1'b0, xdata_internal)
        @(negedge ref_clk);
        xen = 1'b0;
        data_pointer = 24'h000000;
        #1 `CHK("xd_ext_off", 1'b1, xdata_external)
        @(negedge ref_clk);
        xdata_req = 1'b0;
        $display("test xdata done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Counts, verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        test_internal_code();
        test_rewrite();
        test_sfr();
        test_ram();
        test_stack();
        test_xdata();
        test_external_code();
        stop_test();
    end
endmodule
